// *** hw/sli_defines.vh ***
// Constants of the status LED indicator: map, fields, timing
// Function
// - Three display modes select colour mapping
// - SDO transfers flash green fast
// - CAN operational flashes green normal rate
// - Fieldbus cyclic exchange lights steady green
// - Rotor communication flashes yellow slowly
// - Fieldbus setup without exchange: steady yellow
// - Overflow flashes red, error steady red
// - Fieldbus indications outrank CAN indications
// - Clearance mode: alignment acceptable gives green
// - Clearance mode: alignment marginal gives yellow
// - Clearance mode: alignment unacceptable gives red
// - Speed mode: quadrature 90/270 gives green
// - Speed mode: 10 to 30 degree deviation yellow
// - Speed mode: over 30 degrees gives red
`ifndef SLI_DEFINES_VH
`define SLI_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SLI_REG_CTRL    8'h00
`define SLI_REG_LED     8'h04
`define SLI_REG_PHASE   8'h08
`define SLI_REG_IRQ_ST  8'h0C
`define SLI_REG_IRQ_CLR 8'h10
`define SLI_REG_IRQ_EN  8'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SLI_CTRL_RESET  3'h0
`define SLI_MODE_MEAS   2'h0
`define SLI_MODE_CLEAR  2'h1
`define SLI_MODE_SPEED  2'h2
`define SLI_FB_FIT_BIT  2
`define SLI_COL_OFF     2'h0
`define SLI_COL_GREEN   2'h1
`define SLI_COL_YELLOW  2'h2
`define SLI_COL_RED     2'h3
`define SLI_GRADE_OK    2'h0
`define SLI_GRADE_MARG  2'h1
`define SLI_GRADE_BAD   2'h2
`define SLI_IRQ_W       3
// ----------------------------------------
// Timing: clock and tick in ns, flash half periods in ms
// ----------------------------------------
`define SLI_CLK_NS      10
`define SLI_TICK_NS     1000000
`define SLI_FAST_HALF   50
`define SLI_NORM_HALF   250
`define SLI_SLOW_HALF   500
`define SLI_MS_WRAP     10'd999
// ----------------------------------------
// Phase limits in degrees
// ----------------------------------------
`define SLI_DEG_FULL    360
`define SLI_DEG_Q1      90
`define SLI_DEG_Q3      270
`define SLI_DEG_MARG    10
`define SLI_DEG_BAD     30
`endif

// *** hw/sli_phase.v ***
// Phase grader for the two optical speed tracks
`timescale 1ns/1ns
`include "sli_defines.vh"
module sli_phase #(
  parameter CW = 20                      // Counter width, limits slowest track
) (
  // Clock and reset
  input  wire         sys_clk_in,
  input  wire         resetn_in,
  // Synchronised tracks
  input  wire         track_a_in,
  input  wire         track_b_in,
  // Result
  output reg  [1:0]   grade_out,         // OK, marginal or bad
  output reg          valid_out          // Tracks are moving
);
  localparam PW = CW + 9;                // Width of degree products
  localparam [CW-1:0] CMAX = {CW{1'b1}};
  localparam [CW-1:0] CONE = {{(CW-1){1'b0}}, 1'b1}; // Counts restart at one
  // Degree figures sized so the products stay PW bits wide
  localparam [8:0]    DEG_FULL = `SLI_DEG_FULL;
  localparam [8:0]    DEG_Q1   = `SLI_DEG_Q1;
  localparam [8:0]    DEG_Q3   = `SLI_DEG_Q3;
  localparam [8:0]    DEG_MARG = `SLI_DEG_MARG;
  localparam [8:0]    DEG_BAD  = `SLI_DEG_BAD;

  reg  [CW-1:0] per_cnt;                 // Cycles since last A rise
  reg  [CW-1:0] dly_cnt;                 // Cycles from A rise to B rise
  reg  [CW-1:0] dly;                     // Captured delay
  reg           a_d;                     // Edge detect history
  reg           b_d;
  wire          a_rise = track_a_in & ~a_d;
  wire          b_rise = track_b_in & ~b_d;

  // Absolute difference of two products
  function [PW-1:0] absdiff;
    input [PW-1:0] x;
    input [PW-1:0] y;
    begin
      absdiff = (x > y) ? x - y : y - x;
    end
  endfunction

  // Products of the measured period and delay with degree figures
  wire [PW-1:0] d360 = dly * DEG_FULL;
  wire [PW-1:0] p90  = per_cnt * DEG_Q1;
  wire [PW-1:0] p270 = per_cnt * DEG_Q3;
  wire [PW-1:0] e90  = absdiff(d360, p90);
  wire [PW-1:0] e270 = absdiff(d360, p270);
  wire [PW-1:0] dev  = (e90 < e270) ? e90 : e270;
  wire [PW-1:0] lim_m = per_cnt * DEG_MARG;
  wire [PW-1:0] lim_b = per_cnt * DEG_BAD;

  // Measure period of A and A-to-B delay, grade at each A rise
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      per_cnt   <= {CW{1'b0}};
      dly_cnt   <= {CW{1'b0}};
      dly       <= {CW{1'b0}};
      a_d       <= 1'b0;
      b_d       <= 1'b0;
      grade_out <= `SLI_GRADE_BAD;
      valid_out <= 1'b0;
    end else begin
      a_d <= track_a_in;
      b_d <= track_b_in;
      if (b_rise)
        dly <= dly_cnt;
      if (a_rise) begin
        // Restart at one so period and delay count whole cycles
        per_cnt   <= CONE;
        dly_cnt   <= CONE;
        valid_out <= (per_cnt != CMAX);
        // Deviation scaled by period avoids a divider
        if (per_cnt == CMAX)
          grade_out <= `SLI_GRADE_BAD;
        else if (dev < lim_m)
          grade_out <= `SLI_GRADE_OK;
        else if (dev <= lim_b)
          grade_out <= `SLI_GRADE_MARG;
        else
          grade_out <= `SLI_GRADE_BAD;
      end else begin
        if (per_cnt != CMAX)
          per_cnt <= per_cnt + 1'b1;
        else begin
          // Stalled shaft: nothing to judge
          valid_out <= 1'b0;
          grade_out <= `SLI_GRADE_BAD;
        end
        if (dly_cnt != CMAX)
          dly_cnt <= dly_cnt + 1'b1;
      end
    end
  end
endmodule

// *** hw/sli_top.v ***
// Status LED indicator with AHB-Lite register slave
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "sli_defines.vh"
module sli_top #(
  parameter TICK_CYC = `SLI_TICK_NS / `SLI_CLK_NS, // Cycles per 1 ms tick
  parameter CW       = 20                          // Phase counter width
) (
  // Clock and reset
  input  wire         sys_clk_in,
  input  wire         resetn_in,
  // AHB-Lite slave
  input  wire         hsel_in,
  input  wire [7:0]   haddr_in,
  input  wire [1:0]   htrans_in,
  input  wire         hwrite_in,
  input  wire [2:0]   hsize_in,
  input  wire         hready_in,
  input  wire [31:0]  hwdata_in,
  output reg  [31:0]  hrdata_out,
  output reg          hreadyout_out,
  output reg          hresp_out,
  // Internal status conditions, same clock
  input  wire         sdo_active_in,
  input  wire         can_oper_in,
  input  wire         fb_exchange_in,
  input  wire         fb_setup_in,
  input  wire         rotor_comm_in,
  input  wire         ovf_meas_in,
  input  wire         ovf_freq_in,
  input  wire         ovf_analog_in,
  input  wire         error_in,
  input  wire [1:0]   align_grade_in,
  // Optical speed tracks, asynchronous pins
  input  wire         speed_track_a_in,
  input  wire         speed_track_b_in,
  // LED and interrupt
  output reg          led_green_out,
  output reg          led_yellow_out,
  output reg          led_red_out,
  output reg          irq_out
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [2:0]  ctrl;                      // Mode and fieldbus fitted
  reg  [`SLI_IRQ_W-1:0] irq_st;          // Sticky events
  reg  [`SLI_IRQ_W-1:0] irq_en;          // Event enables
  reg         dp_wr;                     // Write data phase pending
  reg  [7:0]  dp_addr;                   // Address of that write
  reg  [16:0] tick_cnt;                  // Prescaler to 1 ms
  reg         tick;                      // One-cycle 1 ms enable
  reg  [9:0]  ms_cnt;                    // Millisecond phase 0..999
  reg  [1:0]  sa;                        // Track A synchroniser
  reg  [1:0]  sb;                        // Track B synchroniser
  reg  [1:0]  colour;                    // Chosen colour
  reg         flash;                     // Chosen pattern flashes
  reg         lit;                       // Flash phase of chosen rate
  reg         err_d;                     // Edge history for events
  reg         ovf_d;
  reg  [1:0]  grade_d;
  reg  [1:0]  next_colour;
  reg         next_flash;
  reg  [1:0]  next_rate;                 // 0 fast, 1 normal, 2 slow
  reg  [31:0] rd_val;
  wire [1:0]  mode = ctrl[1:0];
  wire        fb_fit = ctrl[`SLI_FB_FIT_BIT];
  wire        ovf_any = ovf_meas_in | ovf_freq_in | ovf_analog_in;
  wire [1:0]  ph_grade;
  wire        ph_valid;
  wire        addr_ok = hsel_in & hready_in & htrans_in[1];
  wire [`SLI_IRQ_W-1:0] ev;

  // Flash phase windows derived from the millisecond counter
  wire ph_fast = (ms_cnt % (2 * `SLI_FAST_HALF)) < `SLI_FAST_HALF;
  wire ph_norm = (ms_cnt % (2 * `SLI_NORM_HALF)) < `SLI_NORM_HALF;
  wire ph_slow = ms_cnt < `SLI_SLOW_HALF;

  // Map an alignment grade onto a steady colour
  function [1:0] grade_col;
    input [1:0] g;
    begin
      case (g)
        `SLI_GRADE_OK:   grade_col = `SLI_COL_GREEN;
        `SLI_GRADE_MARG: grade_col = `SLI_COL_YELLOW;
        default:         grade_col = `SLI_COL_RED;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers and phase grader
  // ----------------------------------------
  // Two stages before the grader looks at the tracks
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sa <= 2'h0;
      sb <= 2'h0;
    end else begin
      sa <= {sa[0], speed_track_a_in};
      sb <= {sb[0], speed_track_b_in};
    end
  end

  sli_phase #(
    .CW         (CW)
  ) u_phase (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .track_a_in (sa[1]),
    .track_b_in (sb[1]),
    .grade_out  (ph_grade),
    .valid_out  (ph_valid)
  );

  // ----------------------------------------
  // Flash timebase
  // ----------------------------------------
  // One tick per ms; all three rates share one counter so they stay fixed
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
      ms_cnt   <= 10'h000;
    end else begin
      tick <= 1'b0;
      if (tick_cnt == TICK_CYC[16:0] - 17'h00001) begin
        tick_cnt <= 17'h00000;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 17'h00001;
      end
      if (tick) begin
        if (ms_cnt == `SLI_MS_WRAP)
          ms_cnt <= 10'h000;
        else
          ms_cnt <= ms_cnt + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // Pattern selection
  // ----------------------------------------
  // Priority chain in measurement mode; the first match wins
  always @* begin
    next_colour = `SLI_COL_OFF;
    next_flash  = 1'b0;
    next_rate   = 2'h0;
    case (mode)
      `SLI_MODE_CLEAR: begin
        // Grade comes from the air gap monitor
        next_colour = grade_col(align_grade_in);
      end
      `SLI_MODE_SPEED: begin
        // A still shaft reads red until the tracks move
        next_colour = grade_col(ph_grade);
      end
      `SLI_MODE_MEAS: begin
        if (error_in) begin
          next_colour = `SLI_COL_RED;
        end else if (ovf_any) begin
          next_colour = `SLI_COL_RED;
          next_flash  = 1'b1;
          next_rate   = 2'h1;
        end else if (fb_fit && fb_exchange_in) begin
          next_colour = `SLI_COL_GREEN;
        end else if (fb_fit && fb_setup_in) begin
          next_colour = `SLI_COL_YELLOW;
        end else if (sdo_active_in) begin
          next_colour = `SLI_COL_GREEN;
          next_flash  = 1'b1;
          next_rate   = 2'h0;
        end else if (can_oper_in) begin
          next_colour = `SLI_COL_GREEN;
          next_flash  = 1'b1;
          next_rate   = 2'h1;
        end else if (rotor_comm_in) begin
          next_colour = `SLI_COL_YELLOW;
          next_flash  = 1'b1;
          next_rate   = 2'h2;
        end
      end
      default: begin
        // Unused mode code leaves the LED dark
        next_colour = `SLI_COL_OFF;
      end
    endcase
  end

  // ----------------------------------------
  // LED drivers
  // ----------------------------------------
  // Registered so the pins never glitch on a priority change
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      colour         <= `SLI_COL_OFF;
      flash          <= 1'b0;
      lit            <= 1'b0;
      led_green_out  <= 1'b0;
      led_yellow_out <= 1'b0;
      led_red_out    <= 1'b0;
    end else begin
      colour <= next_colour;
      flash  <= next_flash;
      case (next_rate)
        2'h0:    lit <= ph_fast;
        2'h1:    lit <= ph_norm;
        default: lit <= ph_slow;
      endcase
      led_green_out  <= (colour == `SLI_COL_GREEN)  && (!flash || lit);
      led_yellow_out <= (colour == `SLI_COL_YELLOW) && (!flash || lit);
      led_red_out    <= (colour == `SLI_COL_RED)    && (!flash || lit);
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  // Error rise, overflow rise, speed grade change
  assign ev = {(ph_grade != grade_d), ovf_any & ~ovf_d, error_in & ~err_d};

  // Set wins over a clear in the same cycle
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_d   <= 1'b0;
      ovf_d   <= 1'b0;
      grade_d <= `SLI_GRADE_BAD;
      irq_st  <= {`SLI_IRQ_W{1'b0}};
      irq_out <= 1'b0;
    end else begin
      err_d   <= error_in;
      ovf_d   <= ovf_any;
      grade_d <= ph_grade;
      if (dp_wr && dp_addr == `SLI_REG_IRQ_CLR)
        irq_st <= (irq_st & ~hwdata_in[`SLI_IRQ_W-1:0]) | ev;
      else
        irq_st <= irq_st | ev;
      irq_out <= |(irq_st & irq_en);
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Read mux; unmapped and write-only words read zero
  always @* begin
    rd_val = 32'h00000000;
    case (haddr_in)
      `SLI_REG_CTRL:   rd_val = {29'h00000000, ctrl};
      `SLI_REG_LED:    rd_val = {26'h0000000, flash, colour,
                                 led_red_out, led_yellow_out, led_green_out};
      `SLI_REG_PHASE:  rd_val = {29'h00000000, ph_valid, ph_grade};
      `SLI_REG_IRQ_ST: rd_val = {29'h00000000, irq_st};
      `SLI_REG_IRQ_EN: rd_val = {29'h00000000, irq_en};
      default:         rd_val = 32'h00000000;
    endcase
  end

  // Zero wait states; read data latched at the address phase
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      dp_wr         <= 1'b0;
      dp_addr       <= 8'h00;
      ctrl          <= `SLI_CTRL_RESET;
      irq_en        <= {`SLI_IRQ_W{1'b0}};
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (hready_in) begin
        dp_wr   <= addr_ok & hwrite_in;
        dp_addr <= {haddr_in[7:2], 2'h0};
      end
      if (addr_ok && !hwrite_in)
        hrdata_out <= rd_val;
      // Data phase write; the mode takes effect the next cycle
      if (dp_wr) begin
        case (dp_addr)
          `SLI_REG_CTRL:   ctrl   <= hwdata_in[2:0];
          `SLI_REG_IRQ_EN: irq_en <= hwdata_in[`SLI_IRQ_W-1:0];
          default:         ctrl   <= ctrl;
        endcase
      end
    end
  end
endmodule

// *** bench/sli_properties.sv ***
// Checker for the status LED indicator ports
`timescale 1ns/1ns
module sli_properties (
  // Clock, reset and bus
  input logic        sys_clk_in,
  input logic        resetn_in,
  input logic        hsel_in,
  input logic [7:0]  haddr_in,
  input logic [1:0]  htrans_in,
  input logic        hwrite_in,
  input logic [31:0] hwdata_in,
  input logic        hreadyout_out,
  input logic        hresp_out,
  // Conditions
  input logic        sdo_active_in,
  input logic        can_oper_in,
  input logic        fb_exchange_in,
  input logic        fb_setup_in,
  input logic        rotor_comm_in,
  input logic        ovf_meas_in,
  input logic        ovf_freq_in,
  input logic        ovf_analog_in,
  input logic        error_in,
  input logic [1:0]  align_grade_in,
  // LED and interrupt
  input logic        led_green_out,
  input logic        led_yellow_out,
  input logic        led_red_out,
  input logic        irq_out
);
  // ----------------------------------------
  // Shadows of the written registers
  // ----------------------------------------
  logic [7:0] adr_q;  // Write address held for data phase
  logic       wr_q;   // Write data phase pending
  logic [2:0] ctrl;   // Control shadow
  logic [2:0] en;     // Interrupt enable shadow
  logic [1:0] up;     // Edges since reset, saturating
  wire  [8:0] cnd = {error_in, ovf_analog_in, ovf_freq_in, ovf_meas_in, rotor_comm_in,
                     fb_setup_in, fb_exchange_in, can_oper_in, sdo_active_in};
  wire        ok  = (up == 2'h3);  // Two-cycle history is valid
  wire  [2:0] led = {led_red_out, led_yellow_out, led_green_out};
  // Track writes so the checker knows the mode
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {adr_q, wr_q, ctrl, en, up} <= '0;
    end else begin
      wr_q  <= hsel_in & htrans_in[1] & hwrite_in;
      adr_q <= haddr_in;
      if (wr_q && adr_q[7:2] == 6'h00) ctrl <= hwdata_in[2:0];
      if (wr_q && adr_q[7:2] == 6'h05) en <= hwdata_in[2:0];
      if (up != 2'h3) up <= up + 2'h1;
    end
  end
  // ----------------------------------------
  // Properties; LED pins lag inputs by two edges
  // ----------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_one_colour: assert property ($onehot0(led))
    else $error("two LED colours lit");
  chk_error_red: assert property (ok && $past(ctrl[1:0], 2) == 2'h0 && $past(cnd[8], 2)
    |-> led == 3'h4) else $error("error not steady red");
  chk_ovf_red: assert property (ok && $past(ctrl[1:0], 2) == 2'h0
    && $past(cnd[8:5], 2) != 4'h0 |-> led[1:0] == 2'h0) else $error("overflow not red");
  chk_fb_green: assert property (ok && $past(ctrl, 2) == 3'h4 && $past(cnd[8:5], 2) == 4'h0
    && $past(cnd[2], 2) |-> led == 3'h1) else $error("exchange not steady green");
  chk_fb_yellow: assert property (ok && $past(ctrl, 2) == 3'h4 && $past(cnd[8:5], 2) == 4'h0
    && $past(cnd[3:2], 2) == 2'h2 |-> led == 3'h2) else $error("setup not steady yellow");
  chk_rotor_yellow: assert property (ok && $past(ctrl, 2) == 3'h0 && $past(cnd, 2) == 9'h010
    |-> led[2] == 1'b0 && led[0] == 1'b0) else $error("rotor comm not yellow");
  chk_clear_map: assert property (ok && $past(ctrl[1:0], 2) == 2'h1
    |-> led == ($past(align_grade_in, 2) == 2'h0 ? 3'h1 : $past(align_grade_in, 2) == 2'h1 ? 3'h2 : 3'h4))
    else $error("alignment colour wrong");
  chk_speed_lit: assert property (ok && $past(ctrl[1:0], 2) == 2'h2 |-> led != 3'h0)
    else $error("speed mode shows no colour");
  chk_dark_mode: assert property (ok && $past(ctrl[1:0], 2) == 2'h3 |-> led == 3'h0)
    else $error("dark mode lit");
  chk_irq_masked: assert property (en == 3'h0 && $past(en) == 3'h0 |-> !irq_out)
    else $error("interrupt while disabled");
  chk_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or not okay");
  cov_error_red: cover property (led_red_out && error_in);
  cov_clear_yel: cover property ($past(ctrl[1:0], 2) == 2'h1 && led_yellow_out);
  cov_irq: cover property (irq_out);
endmodule

bind sli_top sli_properties sli_properties_i (.*);

// *** bench/sli_track_model.sv ***
// Optical speed sensor model driving both tracks
`timescale 1ns/1ns
module sli_track_model #(
  parameter PER = 360  // Cycles per period, one cycle per degree
) (
  // Clock and control
  input  wire       sys_clk_in,
  input  wire       run_in,       // Rotor turning
  input  wire [8:0] lag_in,       // Track b lag in degrees
  // Tracks
  output reg        track_a_out = 1'b0,
  output reg        track_b_out = 1'b0
);
  integer cnt = 0;  // Position within the period
  // A stopped rotor leaves both tracks at their last level
  always @(posedge sys_clk_in) begin
    if (run_in) begin
      cnt         <= (cnt + 1) % PER;
      track_a_out <= cnt < PER / 2;
      track_b_out <= (cnt + PER - lag_in) % PER < PER / 2;
    end
  end
endmodule

// *** bench/sli_top_tb.sv ***
// Self-checking bench for the status LED indicator
`timescale 1ns/1ns
`include "sli_defines.vh"
module sli_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] ctrl;  // Mode and fieldbus fitted
    logic [8:0] cnd;   // Conditions, error at the top
    logic [1:0] grd;   // Alignment grade
    logic [8:0] lag;   // Track lag in degrees
    logic [1:0] col;   // Expected colour
    logic [3:0] rise;  // Flashes per window, 0 steady
  } sli_row_t;
  logic sys_clk_in = 1'b0, resetn_in = 1'b0, hsel_in, hwrite_in, irq_out;
  logic [7:0] haddr_in;
  logic [1:0] htrans_in, align_grade_in;
  logic [2:0] hsize_in = 3'h2;  // Word transfers only
  logic [31:0] hwdata_in, hrdata_out, q;
  logic hreadyout_out, hresp_out, speed_track_a_in, speed_track_b_in, run;
  logic sdo_active_in, can_oper_in, fb_exchange_in, fb_setup_in, rotor_comm_in;
  logic ovf_meas_in, ovf_freq_in, ovf_analog_in, error_in;
  logic led_green_out, led_yellow_out, led_red_out;
  logic [8:0] lag;
  wire [2:0] leds = {led_red_out, led_yellow_out, led_green_out};
  int n_fail = 0, total_checks = 0, on [3], rises, win, exp_on;
  sli_row_t r;
  // Colours: 1 green, 2 yellow, 3 red; flashes 10 fast, 2 normal, 1 slow
  sli_row_t rows [22] = '{
    '{3'h4, 9'h1FF, 2'h0, 9'h0, 2'h3, 4'h0}, '{3'h4, 9'h0FF, 2'h0, 9'h0, 2'h3, 4'h2},
    '{3'h0, 9'h040, 2'h0, 9'h0, 2'h3, 4'h2}, '{3'h0, 9'h080, 2'h0, 9'h0, 2'h3, 4'h2},
    '{3'h4, 9'h01F, 2'h0, 9'h0, 2'h1, 4'h0}, '{3'h4, 9'h01B, 2'h0, 9'h0, 2'h2, 4'h0},
    '{3'h0, 9'h01F, 2'h0, 9'h0, 2'h1, 4'hA}, '{3'h0, 9'h012, 2'h0, 9'h0, 2'h1, 4'h2},
    '{3'h0, 9'h010, 2'h0, 9'h0, 2'h2, 4'h1}, '{3'h0, 9'h000, 2'h0, 9'h0, 2'h0, 4'h0},
    '{3'h1, 9'h100, 2'h0, 9'h0, 2'h1, 4'h0}, '{3'h1, 9'h100, 2'h1, 9'h0, 2'h2, 4'h0},
    '{3'h1, 9'h000, 2'h2, 9'h0, 2'h3, 4'h0}, '{3'h1, 9'h000, 2'h3, 9'h0, 2'h3, 4'h0},
    '{3'h3, 9'h100, 2'h0, 9'h0, 2'h0, 4'h0}, '{3'h2, 9'h0, 2'h0, 9'h05A, 2'h1, 4'h0},
    '{3'h2, 9'h0, 2'h0, 9'h10E, 2'h1, 4'h0}, '{3'h2, 9'h0, 2'h0, 9'h063, 2'h1, 4'h0},
    '{3'h2, 9'h0, 2'h0, 9'h064, 2'h2, 4'h0}, '{3'h2, 9'h0, 2'h0, 9'h078, 2'h2, 4'h0},
    '{3'h2, 9'h0, 2'h0, 9'h079, 2'h3, 4'h0}, '{3'h2, 9'h0, 2'h0, 9'h0B4, 2'h3, 4'h0}};
  // ----------------------------------------
  // Design, sensor model and clock
  // ----------------------------------------
  sli_top #(.TICK_CYC(10), .CW(12)) sli_top_i (.hready_in(hreadyout_out), .*);
  sli_track_model sli_track_model_i (.sys_clk_in(sys_clk_in), .run_in(run),
    .lag_in(lag), .track_a_out(speed_track_a_in), .track_b_out(speed_track_b_in));
  always #5 sys_clk_in = ~sys_clk_in;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic edge_rdy;
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk_in);
      if (hreadyout_out === 1'b1) break;
    end
    if (k == 50) begin
      n_fail++;
      conclude;
    end
  endtask
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in  <= a;
    hwrite_in <= w;
    edge_rdy();
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    edge_rdy();
    q = hrdata_out;
  endtask
  // Count lit cycles and rising edges over n cycles
  task automatic measure(input int n);
    logic [2:0] p;
    on = '{0, 0, 0};
    rises = 0;
    @(negedge sys_clk_in);
    p = leds;
    repeat (n) begin
      @(negedge sys_clk_in);
      for (int k = 0; k < 3; k++) begin
        on[k] += leds[k];
        rises += leds[k] & !p[k];
      end
      p = leds;
    end
    @(posedge sys_clk_in);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hsel_in, htrans_in, hwrite_in, haddr_in, hwdata_in, run, lag} = '0;
    {error_in, ovf_analog_in, ovf_freq_in, ovf_meas_in, rotor_comm_in} = '0;
    {fb_setup_in, fb_exchange_in, can_oper_in, sdo_active_in, align_grade_in} = '0;
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    check("leds after reset", leds, 3'h0);
    bus(`SLI_REG_CTRL, 1'b0, 0);
    check("ctrl reset", q, 0);
    bus(`SLI_REG_IRQ_ST, 1'b0, 0);
    check("status reset", q, 0);
    foreach (rows[i]) begin
      r = rows[i];
      bus(`SLI_REG_CTRL, 1'b1, {29'h0, r.ctrl});
      {error_in, ovf_analog_in, ovf_freq_in, ovf_meas_in, rotor_comm_in, fb_setup_in,
       fb_exchange_in, can_oper_in, sdo_active_in} <= r.cnd;
      align_grade_in <= r.grd;
      lag <= r.lag;
      run <= 1'b1;
      repeat (800) @(posedge sys_clk_in);
      win = (r.rise != 0) ? 10000 : 200;
      measure(win);
      for (int k = 0; k < 3; k++) begin
        exp_on = (r.col == k + 1) ? ((r.rise != 0) ? win / 2 : win) : 0;
        check("led lit cycles", on[k], exp_on);
      end
      check("led flashes", rises, r.rise);
    end
    // Rotor stops: period counter saturates, grade red
    run <= 1'b0;
    repeat (4300) @(posedge sys_clk_in);
    check("stalled colour", leds, 3'h4);
    bus(`SLI_REG_PHASE, 1'b0, 0);
    check("stalled grade", q[2:0], 3'h2);
    // Interrupt raise, clear and mask
    bus(`SLI_REG_IRQ_CLR, 1'b1, 32'h7);
    bus(`SLI_REG_IRQ_EN, 1'b1, 32'h1);
    error_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    check("irq raised", irq_out, 1'b1);
    bus(`SLI_REG_IRQ_CLR, 1'b1, 32'h1);
    repeat (3) @(posedge sys_clk_in);
    check("irq cleared", irq_out, 1'b0);
    bus(`SLI_REG_IRQ_EN, 1'b1, 32'h0);
    error_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    error_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    check("irq masked", irq_out, 1'b0);
    bus(`SLI_REG_IRQ_ST, 1'b0, 0);
    check("status sticky", q[0], 1'b1);
    bus(8'h18, 1'b0, 0);
    check("unmapped read", q, 0);
    conclude;
  end
endmodule
